// ==== rtl/sbsp_top.sv ====
// Block stream serial port: streams engine RAM words out with frame pulses
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "sbsp_cfg.svh"

module sbsp_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [31:0] bus_rdata,
  input wire logic mux_sync,
  input wire logic receiver_ready,
  input wire logic [31:0] ram_rdata,
  output logic [`SBSP_RAM_AW-1:0] ram_addr,
  output logic shift_clk,
  output logic serial_data_out,
  output logic frame_pulse
);

  // ---------------------------------------------------------------
  // Field length decode
  // ---------------------------------------------------------------
  // Bits per field; zero means the whole block is one field
  function automatic logic [5:0] field_len(input logic [1:0] fs);
    case (fs)
      2'h1: field_len = 6'h08;
      2'h2: field_len = 6'h10;
      2'h3: field_len = 6'h20;
      default: field_len = 6'h00;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [2:0] rdy_sync; // Three stages for the ready pin
  logic [2:0] sync_sync; // Three stages for the mux sync
  logic rdy_state; // Filtered ready level
  logic sync_state; // Filtered mux sync level
  logic next_rdy_state;
  logic next_sync_state;
  logic start_evt; // Rising mux sync seen

  // A change counts only when stages one and two agree
  always_comb begin
    next_rdy_state = (rdy_sync[1] == rdy_sync[2]) ? rdy_sync[2] : rdy_state;
    next_sync_state = (sync_sync[1] == sync_sync[2]) ? sync_sync[2] : sync_state;
  end

  // Sync chains; stage zero feeds only stage one
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdy_sync <= 3'h0;
      sync_sync <= 3'h0;
      rdy_state <= 1'b0;
      sync_state <= 1'b0;
    end else if (ce) begin
      rdy_sync <= {rdy_sync[1:0], receiver_ready};
      sync_sync <= {sync_sync[1:0], mux_sync};
      rdy_state <= next_rdy_state;
      sync_state <= next_sync_state;
    end
  end

  // Sync rises one slow tick before the engine pass
  assign start_evt = next_sync_state && !sync_state;

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic serial_port_enable; // Master enable
  logic fast_clock_select; // Fast shift rate
  logic clock_gate_select; // Gate clock when idle
  logic ready_handshake_enable; // Honour ready input
  logic [1:0] field_size_select; // Field framing
  logic frame_polarity; // Invert frame pulse
  logic [`SBSP_RAM_AW-1:0] block_first_word; // First word address
  logic [`SBSP_RAM_AW-1:0] block_last_word; // Last word address
  logic [31:0] next_rdata;
  logic [31:0] ctrl_word;
  sbsp_pkg::sbsp_state_t state; // Sequencer state

  assign ctrl_word = {25'h0, frame_polarity, field_size_select, ready_handshake_enable,
                      clock_gate_select, fast_clock_select, serial_port_enable};

  // Read decode; unmapped offsets answer zero
  always_comb begin
    next_rdata = 32'h0;
    if (bus_rd) begin
      case (bus_addr)
        `SBSP_OFF_CTRL: next_rdata = ctrl_word;
        `SBSP_OFF_FIRST: next_rdata = {23'h0, block_first_word};
        `SBSP_OFF_LAST: next_rdata = {23'h0, block_last_word};
        `SBSP_OFF_STATUS: begin
          next_rdata[0] = (state != sbsp_pkg::ST_IDLE);
          next_rdata[1] = (state == sbsp_pkg::ST_WAIT);
          next_rdata[`SBSP_STAT_ADDR_LO +: `SBSP_RAM_AW] = ram_addr;
        end
        default: next_rdata = 32'h0;
      endcase
    end
  end

  // Writes take effect at once; read data stand one cycle only
  always_ff @(posedge core_clk) begin
    if (rst) begin
      serial_port_enable <= 1'b0;
      fast_clock_select <= 1'b0;
      clock_gate_select <= 1'b0;
      ready_handshake_enable <= 1'b0;
      field_size_select <= 2'h0;
      frame_polarity <= 1'b0;
      block_first_word <= `SBSP_RST_FIRST;
      block_last_word <= `SBSP_RST_LAST;
      bus_rdata <= 32'h0;
    end else if (ce) begin
      bus_rdata <= next_rdata;
      if (bus_wr && bus_addr == `SBSP_OFF_CTRL) begin
        serial_port_enable <= bus_wdata[`SBSP_CTRL_EN];
        fast_clock_select <= bus_wdata[`SBSP_CTRL_FAST];
        clock_gate_select <= bus_wdata[`SBSP_CTRL_GATE];
        ready_handshake_enable <= bus_wdata[`SBSP_CTRL_RDYEN];
        field_size_select <= bus_wdata[`SBSP_CTRL_FSIZE_HI:`SBSP_CTRL_FSIZE_LO];
        frame_polarity <= bus_wdata[`SBSP_CTRL_FPOL];
      end
      if (bus_wr && bus_addr == `SBSP_OFF_FIRST) begin
        block_first_word <= bus_wdata[`SBSP_RAM_AW-1:0];
      end
      if (bus_wr && bus_addr == `SBSP_OFF_LAST) begin
        block_last_word <= bus_wdata[`SBSP_RAM_AW-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Shift clock divider
  // ---------------------------------------------------------------
  logic [2:0] div_cnt; // Position within one shift period
  logic [2:0] next_div_cnt;
  logic [2:0] div_top; // Last count of the period
  logic [2:0] high_len; // Cycles with the clock high
  logic rise_tick; // Shift clock rises at this edge
  logic gate_on; // Clock allowed out
  logic next_sclk;
  sbsp_pkg::sbsp_state_t next_state;

  // 10 MHz rounds up to three core cycles, the nearest slower period
  always_comb begin
    div_top = fast_clock_select ? 3'(`SBSP_FAST_DIV - 1) : 3'(`SBSP_SLOW_DIV - 1);
    high_len = fast_clock_select ? 3'(`SBSP_FAST_DIV / 2) : 3'(`SBSP_SLOW_DIV / 2);
    rise_tick = (div_cnt >= div_top);
    next_div_cnt = rise_tick ? 3'h0 : div_cnt + 3'h1;
    // Gate opens only once the sequencer has left idle, so the start edge adds no rise
    gate_on = !clock_gate_select
              || (state != sbsp_pkg::ST_IDLE && next_state != sbsp_pkg::ST_IDLE);
    // Rise only on a period boundary: enabling or ungating never starts a runt pulse; disabling or gating while high cuts the pulse short
    next_sclk = serial_port_enable && gate_on
                && (rise_tick || (shift_clk && (next_div_cnt < high_len)));
  end

  // Divider keeps running so the free clock never stops while the port is enabled
  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_cnt <= 3'h0;
      shift_clk <= 1'b0;
    end else if (ce) begin
      div_cnt <= next_div_cnt;
      shift_clk <= next_sclk;
    end
  end

  // ---------------------------------------------------------------
  // Transfer sequencer
  // ---------------------------------------------------------------
  logic [2:0] step_cnt; // Lead-in or tail rises seen
  logic [4:0] bit_cnt; // Bits left in shifted word
  logic [5:0] field_cnt; // Bits left in field
  logic [31:0] shreg; // Word being shifted
  logic [31:0] word_buf; // Prefetched next word
  logic last_word; // Shifted word is the block's last
  logic frame_act; // Frame pulse, active high
  logic data_q; // Serial data bit
  logic ready_ok; // Ready as seen at field start
  logic block_done;
  logic field_done;
  logic [2:0] lead_top;
  logic [2:0] next_step_cnt;
  logic [4:0] next_bit_cnt;
  logic [5:0] next_field_cnt;
  logic [31:0] next_shreg;
  logic [`SBSP_RAM_AW-1:0] next_ram_addr;
  logic next_last_word;
  logic next_frame_act;
  logic next_data;

  // Handshake disabled reads as permanently ready
  assign ready_ok = !ready_handshake_enable || rdy_state;
  assign block_done = last_word && (bit_cnt == 5'h0);
  assign field_done = (field_size_select != 2'h0) && (field_cnt == 6'h0);
  assign lead_top = fast_clock_select ? 3'(`SBSP_LEAD_FAST - 1) : 3'(`SBSP_LEAD_SLOW - 1);

  // Next-state logic; start and disable act at once, all else moves only on a shift clock rise
  always_comb begin
    next_state = state;
    next_step_cnt = step_cnt;
    next_bit_cnt = bit_cnt;
    next_field_cnt = field_cnt;
    next_shreg = shreg;
    next_ram_addr = ram_addr;
    next_last_word = last_word;
    next_frame_act = frame_act;
    next_data = data_q;
    if (!serial_port_enable) begin
      next_state = sbsp_pkg::ST_IDLE;
      next_frame_act = 1'b0;
      next_data = 1'b0;
    end else if (state == sbsp_pkg::ST_IDLE) begin
      // A sync during a transfer is ignored so the overrun completes
      if (start_evt) begin
        next_state = sbsp_pkg::ST_LEAD;
        next_step_cnt = 3'h0;
        next_bit_cnt = 5'h0;
        next_last_word = 1'b0;
        next_ram_addr = block_first_word;
      end
    end else if (rise_tick) begin
      next_frame_act = 1'b0;
      case (state)
        sbsp_pkg::ST_LEAD: begin
          if (step_cnt == lead_top) begin
            next_state = ready_ok ? sbsp_pkg::ST_FRAME : sbsp_pkg::ST_WAIT;
            next_frame_act = ready_ok;
            next_field_cnt = field_len(field_size_select);
          end else begin
            next_step_cnt = step_cnt + 3'h1;
          end
        end
        sbsp_pkg::ST_WAIT: begin
          // Ready looked at only before a field (at lead-in end, on each rise while waiting, and at field end), never inside a field
          next_state = ready_ok ? sbsp_pkg::ST_FRAME : sbsp_pkg::ST_WAIT;
          next_frame_act = ready_ok;
          next_field_cnt = field_len(field_size_select);
        end
        sbsp_pkg::ST_FRAME, sbsp_pkg::ST_DATA: begin
          if (state == sbsp_pkg::ST_DATA && block_done) begin
            next_state = sbsp_pkg::ST_TAIL;
            next_step_cnt = 3'h0;
            next_data = 1'b0;
          end else if (state == sbsp_pkg::ST_DATA && field_done) begin
            next_state = ready_ok ? sbsp_pkg::ST_FRAME : sbsp_pkg::ST_WAIT;
            next_frame_act = ready_ok;
            next_field_cnt = field_len(field_size_select);
            next_data = 1'b0;
          end else begin
            next_state = sbsp_pkg::ST_DATA;
            next_field_cnt = field_cnt - 6'h1;
            if (bit_cnt == 5'h0) begin
              // Fresh word from the prefetch buffer, MSB out first
              next_data = word_buf[31];
              next_shreg = {word_buf[30:0], 1'b0};
              next_bit_cnt = 5'h1f;
              next_last_word = (ram_addr >= block_last_word);
              next_ram_addr = ram_addr + 9'h001;
            end else begin
              next_data = shreg[31];
              next_shreg = {shreg[30:0], 1'b0};
              next_bit_cnt = bit_cnt - 5'h1;
            end
          end
        end
        sbsp_pkg::ST_TAIL: begin
          if (step_cnt == 3'(`SBSP_TAIL_RISES - 1)) begin
            next_state = sbsp_pkg::ST_IDLE;
          end else begin
            next_step_cnt = step_cnt + 3'h1;
          end
        end
        default: next_state = sbsp_pkg::ST_IDLE;
      endcase
    end
  end

  // Registers of the sequencer; RAM data sampled every cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= sbsp_pkg::ST_IDLE;
      step_cnt <= 3'h0;
      bit_cnt <= 5'h0;
      field_cnt <= 6'h0;
      shreg <= 32'h0;
      word_buf <= 32'h0;
      ram_addr <= `SBSP_RST_FIRST;
      last_word <= 1'b0;
      frame_act <= 1'b0;
      data_q <= 1'b0;
      serial_data_out <= 1'b0;
      frame_pulse <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      step_cnt <= next_step_cnt;
      bit_cnt <= next_bit_cnt;
      field_cnt <= next_field_cnt;
      shreg <= next_shreg;
      word_buf <= ram_rdata;
      ram_addr <= next_ram_addr;
      last_word <= next_last_word;
      frame_act <= next_frame_act;
      data_q <= next_data;
      serial_data_out <= next_data;
      frame_pulse <= next_frame_act ^ frame_polarity;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst || !ce);

  property p_start_on_sync;
    start_evt && serial_port_enable && state == sbsp_pkg::ST_IDLE |=> state == sbsp_pkg::ST_LEAD;
  endproperty
  a_start_on_sync: assert property (p_start_on_sync) else $error("sync did not start");

  property p_no_restart;
    start_evt && state == sbsp_pkg::ST_DATA |=> state != sbsp_pkg::ST_LEAD;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("transfer restarted");

  // A switch to the fast rate inside the window ends the obligation
  property p_slow_period;
    rise_tick && !fast_clock_select
      |=> (!rise_tick [*4] ##1 rise_tick) or (##[0:4] fast_clock_select);
  endproperty
  a_slow_period: assert property (p_slow_period) else $error("slow period wrong");

  property p_gate_off;
    clock_gate_select && $past(clock_gate_select) && state == sbsp_pkg::ST_IDLE
      && $past(state == sbsp_pkg::ST_IDLE) |-> !shift_clk;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("gated clock running");

  property p_ready_gate;
    $rose(frame_act) |-> $past(ready_ok);
  endproperty
  a_ready_gate: assert property (p_ready_gate) else $error("frame without ready");

  property p_wait_needs_hs;
    state == sbsp_pkg::ST_WAIT |-> ready_handshake_enable;
  endproperty
  a_wait_needs_hs: assert property (p_wait_needs_hs) else $error("waited with no handshake");

  property p_msb_first;
    rise_tick && serial_port_enable && state == sbsp_pkg::ST_FRAME && bit_cnt == 5'h0
      |=> data_q == $past(word_buf[31]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first bit not MSB");

  property p_frame_width;
    $rose(frame_act) |-> ##[1:5] $fell(frame_act);
  endproperty
  a_frame_width: assert property (p_frame_width) else $error("frame too long");

  property p_frame_on_rise;
    $changed(frame_act) |-> $rose(shift_clk) || !serial_port_enable;
  endproperty
  a_frame_on_rise: assert property (p_frame_on_rise) else $error("frame off clock rise");

  property p_idle_quiet;
    state == sbsp_pkg::ST_IDLE |-> !data_q && !frame_act;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("idle outputs active");

  c_frame: cover property ($rose(frame_act));
  c_wait: cover property (state == sbsp_pkg::ST_WAIT ##1 state == sbsp_pkg::ST_FRAME);
  c_done: cover property (state == sbsp_pkg::ST_TAIL ##1 state == sbsp_pkg::ST_IDLE);

endmodule

// ==== include/sbsp_cfg.svh ====
// Constants for the block stream serial port: offsets, fields, resets, timing
`ifndef SBSP_CFG_SVH
`define SBSP_CFG_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define SBSP_OFF_CTRL 8'h00
`define SBSP_OFF_FIRST 8'h04
`define SBSP_OFF_LAST 8'h08
`define SBSP_OFF_STATUS 8'h0c

// ---------------------------------------------------------------
// Control register fields and reset values
// ---------------------------------------------------------------
`define SBSP_CTRL_EN 0
`define SBSP_CTRL_FAST 1
`define SBSP_CTRL_GATE 2
`define SBSP_CTRL_RDYEN 3
`define SBSP_CTRL_FSIZE_LO 4
`define SBSP_CTRL_FSIZE_HI 5
`define SBSP_CTRL_FPOL 6
`define SBSP_STAT_ADDR_LO 16
`define SBSP_RAM_AW 9
`define SBSP_RST_FIRST 9'h000
`define SBSP_RST_LAST 9'h000

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define SBSP_CLK_HZ 25000000
`define SBSP_SLOW_HZ 5000000
`define SBSP_FAST_HZ 10000000
`define SBSP_SLOW_DIV ((`SBSP_CLK_HZ + `SBSP_SLOW_HZ - 1) / `SBSP_SLOW_HZ)
`define SBSP_FAST_DIV ((`SBSP_CLK_HZ + `SBSP_FAST_HZ - 1) / `SBSP_FAST_HZ)
`define SBSP_LEAD_SLOW 3
`define SBSP_LEAD_FAST 4
`define SBSP_TAIL_RISES 3

`endif

// ==== include/sbsp_pkg.sv ====
// Types shared by the block stream serial port
package sbsp_pkg;

  // ---------------------------------------------------------------
  // Transfer sequencer states, one-hot
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_LEAD = 6'h02,
    ST_WAIT = 6'h04,
    ST_FRAME = 6'h08,
    ST_DATA = 6'h10,
    ST_TAIL = 6'h20
  } sbsp_state_t;

endpackage

// ==== dv/sbsp_rx_model.sv ====
// Receiver model: ready source and frame and bit capture for the serial port
`timescale 1ns/1ps

module sbsp_rx_model (
  input wire logic core_clk,
  input wire logic clr,
  input wire logic stall,
  input wire logic pol,
  input wire logic [7:0] flen,
  input wire logic shift_clk,
  input wire logic serial_data_out,
  input wire logic frame_pulse,
  output logic receiver_ready,
  output logic [7:0] n_frames,
  output logic [63:0] bits
);
  // ---------------------------------------------------------------
  // Capture state
  // ---------------------------------------------------------------
  logic prev_clk; // Shift clock as last sampled
  logic [7:0] left; // Bits still owed in this field

  // Rises are found by the core clock, so each one is seen with the bit it launched
  always_ff @(posedge core_clk) begin
    prev_clk <= shift_clk;
    if (clr) begin
      n_frames <= 8'h00;
      bits <= 64'h0;
      left <= 8'h00;
      receiver_ready <= !stall;
    end else if (shift_clk && !prev_clk) begin
      // Outside a clear, ready only moves on a rise, never between them
      receiver_ready <= !stall;
      if (frame_pulse ^ pol) begin
        n_frames <= n_frames + 8'h01;
        left <= flen;
      end else if (left != 8'h00) begin
        // Tail and idle bits beyond the field are not taken
        bits <= {bits[62:0], serial_data_out};
        left <= left - 8'h01;
      end
    end
  end
endmodule

// ==== dv/tb.sv ====
// Testbench: drives the block stream serial port against a receiver model
`timescale 1ns/1ps
`include "sbsp_cfg.svh"

module tb;
  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic core_clk = 1'b0; // 25 MHz core clock
  logic rst = 1'b1; // Synchronous reset
  logic ce = 1'b1; // Clock enable, dropped once in the register test
  logic [7:0] bus_addr = 8'h00; // Register address
  logic [31:0] bus_wdata = 32'h0; // Write data
  logic bus_wr = 1'b0; // Write strobe
  logic bus_rd = 1'b0; // Read strobe
  logic mux_sync = 1'b0; // Engine pass sync
  logic [31:0] ram_rdata = 32'h0; // Engine RAM word
  logic clr = 1'b1; // Model clear
  logic stall = 1'b0; // Model holds ready low
  logic pol = 1'b0; // Frame polarity for the model
  logic [7:0] flen = 8'd32; // Field length for the model
  logic [31:0] bus_rdata;
  logic [8:0] ram_addr;
  logic shift_clk;
  logic serial_data_out;
  logic frame_pulse;
  logic receiver_ready;
  logic [7:0] n_frames;
  logic [63:0] bits;
  int n_mismatch = 0;
  int cmp_count = 0;

  // Only the port drives its output lines; no display driver shares them here
  sbsp_top sbsp_top_inst (.core_clk(core_clk), .rst(rst), .ce(ce), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .mux_sync(mux_sync), .receiver_ready(receiver_ready), .ram_rdata(ram_rdata),
    .ram_addr(ram_addr), .shift_clk(shift_clk), .serial_data_out(serial_data_out),
    .frame_pulse(frame_pulse));

  sbsp_rx_model sbsp_rx_model_inst (.core_clk(core_clk), .clr(clr), .stall(stall), .pol(pol),
    .flen(flen), .shift_clk(shift_clk), .serial_data_out(serial_data_out),
    .frame_pulse(frame_pulse), .receiver_ready(receiver_ready), .n_frames(n_frames),
    .bits(bits));

  // Distinct, asymmetric word per address so bit order errors show
  function automatic logic [31:0] word(input logic [8:0] a);
    return {8'ha5, 7'h00, a, 8'h3c};
  endfunction

  // RAM with one-cycle latency; contents never change under a transfer
  always_ff @(posedge core_clk) ram_rdata <= word(ram_addr);

  // Core clock
  initial begin
    forever #20 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge core_clk);
    bus_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    @(negedge core_clk);
    d = bus_rdata;
    @(posedge core_clk);
  endtask

  task automatic start(input logic [31:0] ctrl, input logic [8:0] f, input logic [8:0] l,
                       input logic [7:0] fl);
    clr <= 1'b1;
    flen <= fl;
    pol <= ctrl[6];
    wr(`SBSP_OFF_FIRST, {23'h0, f});
    wr(`SBSP_OFF_LAST, {23'h0, l});
    wr(`SBSP_OFF_CTRL, ctrl);
    clr <= 1'b0;
  endtask

  // Sync held long enough to pass the input synchroniser
  task automatic go();
    mux_sync <= 1'b1;
    repeat (6) @(posedge core_clk);
    mux_sync <= 1'b0;
  endtask

  task automatic finish(input string nm, input logic [7:0] nf, input logic [63:0] eb);
    logic [31:0] s;
    s = 32'h1;
    for (int i = 0; i < 600 && s[0] !== 1'b0; i++) rd(`SBSP_OFF_STATUS, s);
    chk({nm, " busy"}, 64'h0, s[0]);
    chk({nm, " frames"}, nf, n_frames);
    chk({nm, " bits"}, eb, bits);
    chk({nm, " idle frame"}, pol, frame_pulse);
    chk({nm, " idle data"}, 64'h0, serial_data_out);
    $display("test %s done", nm);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Reset values, unmapped place, and field width of a write
  task automatic t_regs();
    logic [31:0] d;
    for (int k = 0; k < 5; k++) begin
      rd(8'(k * 4), d);
      chk("reset value", 64'h0, d);
    end
    wr(`SBSP_OFF_FIRST, 32'hffffffff);
    rd(`SBSP_OFF_FIRST, d);
    chk("first word width", 64'h1ff, d);
    // Clock enable low: the write must be frozen out
    ce <= 1'b0;
    wr(`SBSP_OFF_FIRST, 32'h0);
    ce <= 1'b1;
    rd(`SBSP_OFF_FIRST, d);
    chk("frozen write", 64'h1ff, d);
    $display("test regs done");
  endtask

  // Whole block, then 8 and 16 bit fields at the fast rate with inverted frame
  task automatic t_field(input int fs);
    if (fs == 0) begin
      start(32'h01, 9'h002, 9'h003, 8'd64);
      go();
      finish("block", 8'd1, {word(9'h002), word(9'h003)});
    end else begin
      start(32'h43 | (32'(fs) << 4), 9'h007, 9'h007, 8'd8 << (fs - 1));
      go();
      finish("split", 8'd4 >> (fs - 1), {32'h0, word(9'h007)});
    end
  endtask

  // Gated clock: still while idle, lead-in before the first frame, period
  task automatic t_gate(input logic fast);
    logic prev;
    int n;
    int c;
    n = 0;
    start(32'h35 | (fast ? 32'h2 : 32'h0), 9'h009, 9'h009, 8'd32);
    prev = shift_clk;
    for (int i = 0; i < 30; i++) begin
      @(negedge core_clk);
      if (shift_clk === 1'b1 && prev === 1'b0) n++;
      prev = shift_clk;
    end
    chk("idle rises", 64'h0, n);
    n = 0;
    @(posedge core_clk);
    mux_sync <= 1'b1;
    for (int i = 0; i < 200 && frame_pulse !== 1'b1; i++) begin
      @(negedge core_clk);
      if (shift_clk === 1'b1 && prev === 1'b0) n++;
      prev = shift_clk;
    end
    chk("lead rises", fast ? 4 : 3, n);
    for (c = 1; c < 20; c++) begin
      @(negedge core_clk);
      if (shift_clk === 1'b1 && prev === 1'b0) break;
      prev = shift_clk;
    end
    chk("shift period", fast ? 3 : 5, c);
    @(posedge core_clk);
    mux_sync <= 1'b0;
    finish("gate", 8'd1, {32'h0, word(9'h009)});
  endtask

  // Handshake: held before the first frame, ignored inside a field, held again
  task automatic t_ready();
    logic [31:0] s;
    stall <= 1'b1;
    start(32'h39, 9'h00a, 9'h00b, 8'd32);
    go();
    repeat (300) @(posedge core_clk);
    chk("held frames", 64'h0, n_frames);
    rd(`SBSP_OFF_STATUS, s);
    chk("waiting status", 64'h3, s[1:0]);
    stall <= 1'b0;
    for (int i = 0; i < 300 && n_frames !== 8'd1; i++) @(posedge core_clk);
    stall <= 1'b1;
    go();
    repeat (400) @(posedge core_clk);
    chk("one field", 64'h1, n_frames);
    chk("first word", {32'h0, word(9'h00a)}, bits);
    stall <= 1'b0;
    finish("ready", 8'd2, {word(9'h00a), word(9'h00b)});
  endtask

  // Disable in mid-block: outputs fall quiet and the port goes idle
  task automatic t_abort();
    logic [31:0] s;
    int n;
    n = 0;
    start(32'h31, 9'h000, 9'h007, 8'd32);
    go();
    for (int i = 0; i < 600 && n_frames !== 8'd2; i++) @(posedge core_clk);
    wr(`SBSP_OFF_CTRL, 32'h30);
    repeat (2) @(posedge core_clk);
    for (int i = 0; i < 40; i++) begin
      @(negedge core_clk);
      if (serial_data_out !== 1'b0 || frame_pulse !== 1'b0) n++;
    end
    chk("quiet after disable", 64'h0, n);
    @(posedge core_clk);
    rd(`SBSP_OFF_STATUS, s);
    chk("busy after disable", 64'h0, s[0]);
    $display("test abort done");
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_regs();
    // Ready low but handshake off, so it must not matter
    stall <= 1'b1;
    start(32'h31, 9'h004, 9'h005, 8'd32);
    go();
    finish("word32", 8'd2, {word(9'h004), word(9'h005)});
    stall <= 1'b0;
    for (int fs = 0; fs < 3; fs++) t_field(fs);
    t_gate(1'b0);
    t_gate(1'b1);
    t_ready();
    t_abort();
    wrap_up();
  end

  // Cuts a hang well beyond the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    wrap_up();
  end
endmodule
